// [ccp_timebase_select_regs.vh]
// Register map, field positions and encodings of the capture timebase selector
`ifndef CCP_TIMEBASE_SELECT_REGS_VH
`define CCP_TIMEBASE_SELECT_REGS_VH

`define TSEL0_OFFSET       4'h0
`define TSEL0_WORD         2'h0
`define TSEL0_RESET        8'h00
`define UNIT1_SEL_LSB      0
`define UNIT2_SEL_LSB      3
`define UNIT3_SEL_LSB      6
`define SEL_T1_T2          3'h0
`define SEL_T3_T4          3'h1
`define SEL_T3_T6          3'h2
`define SEL_T3_T8          3'h3
`define SEL_T3_T10         3'h4
`define SEL_T3_T12         3'h5
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

// [ccp_timebase_select.v]
// Timebase selector for three enhanced capture units with AXI4-Lite register access
//
// Summary of operation
// - Bits 2:0 select the timer pair feeding unit 1.
// - Codes 000..011 give timer1/2, timer3/4, timer3/6, timer3/8.
// - Bits 5:3 select unit 2 timer pair, same encoding as unit 1.
// - Bits 7:6 select unit 3; 01 timer3/4, 10 timer3/6.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`include "ccp_timebase_select_regs.vh"

module ccp_timebase_select #(
  parameter CNT_W       = 16,
  parameter LARGE_PARTS = 1
) (
  // Clock and reset
  input  wire               aclk,
  input  wire               aresetn,
  // AXI4-Lite write address
  input  wire [3:0]         s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]         s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // Timer counts and periods
  input  wire [6*CNT_W-1:0] timer_count,
  input  wire [6*CNT_W-1:0] timer_period,
  // Selected timebase per unit
  output reg  [CNT_W-1:0]   unit1_count,
  output reg  [CNT_W-1:0]   unit1_period,
  output reg  [CNT_W-1:0]   unit2_count,
  output reg  [CNT_W-1:0]   unit2_period,
  output reg  [CNT_W-1:0]   unit3_count,
  output reg  [CNT_W-1:0]   unit3_period,
  // Decoded selections
  output wire [2:0]         unit1_timebase_sel,
  output wire [2:0]         unit2_timebase_sel,
  output wire [1:0]         unit3_timebase_sel
);

  // Timer slots: 0 timer1, 1 timer3 for counts; periods 0 timer2, 1..5 timer4..12
  reg  [7:0]  tsel_reg;
  reg         aw_held_reg;
  reg         w_held_reg;
  reg  [3:0]  awaddr_reg;
  reg  [7:0]  wdata_reg;
  reg         wstrb0_reg;
  wire        do_write;
  wire        aw_take;
  wire        w_take;
  wire        rd_take;
  wire        tsel_wr_hit;
  wire        tsel_rd_hit;
  wire        reg_update;
  wire [2:0]  unit3_code;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write      = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign rd_take       = s_axi_arvalid & s_axi_arready;

  // Count source: code 0 uses timer1, others timer3
  function [CNT_W-1:0] pick_count;
    input [2:0]         code;
    input [6*CNT_W-1:0] bus;
    begin
      if (code == `SEL_T1_T2)
        pick_count = bus[0 +: CNT_W];
      else
        pick_count = bus[CNT_W +: CNT_W];
    end
  endfunction

  // Period source by pair code; reserved codes fall back to timer2
  function [CNT_W-1:0] pick_period;
    input [2:0]         code;
    input [6*CNT_W-1:0] bus;
    begin
      case (code)
        `SEL_T3_T4:  pick_period = bus[1*CNT_W +: CNT_W];
        `SEL_T3_T6:  pick_period = bus[2*CNT_W +: CNT_W];
        `SEL_T3_T8:  pick_period = bus[3*CNT_W +: CNT_W];
        `SEL_T3_T10: pick_period = (LARGE_PARTS != 0) ? bus[4*CNT_W +: CNT_W] : bus[0 +: CNT_W];
        `SEL_T3_T12: pick_period = (LARGE_PARTS != 0) ? bus[5*CNT_W +: CNT_W] : bus[0 +: CNT_W];
        default:     pick_period = bus[0 +: CNT_W];
      endcase
    end
  endfunction

  // Register decode: one word, selected by address bits 3:2
  function is_tsel0;
    input [3:0] addr;
    begin
      is_tsel0 = (addr[3:2] == `TSEL0_WORD);
    end
  endfunction

  assign tsel_wr_hit = is_tsel0(awaddr_reg);
  assign tsel_rd_hit = is_tsel0(s_axi_araddr);
  // byte lane 0 carries all eight bits
  assign reg_update  = do_write & tsel_wr_hit & wstrb0_reg;

  assign unit1_timebase_sel = tsel_reg[`UNIT1_SEL_LSB +: 3];
  assign unit2_timebase_sel = tsel_reg[`UNIT2_SEL_LSB +: 3];
  assign unit3_timebase_sel = tsel_reg[`UNIT3_SEL_LSB +: 2];
  // two-bit code widened for the shared decode
  assign unit3_code = {1'b0, unit3_timebase_sel};

  // Write address capture
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 4'h0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Write data capture; only byte lane 0 holds register bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Write response; unmapped words answer SLVERR
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= tsel_wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Selector register
  always @(posedge aclk) begin
    if (!aresetn) begin
      tsel_reg <= `TSEL0_RESET;
    end else if (reg_update) begin
      tsel_reg <= wdata_reg;
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      if (tsel_rd_hit) begin
        s_axi_rdata <= {24'h00_0000, tsel_reg};
        s_axi_rresp <= `AXI_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `AXI_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Timebase steering, registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      unit1_count  <= {CNT_W{1'b0}};
      unit1_period <= {CNT_W{1'b0}};
      unit2_count  <= {CNT_W{1'b0}};
      unit2_period <= {CNT_W{1'b0}};
      unit3_count  <= {CNT_W{1'b0}};
      unit3_period <= {CNT_W{1'b0}};
    end else begin
      unit1_count  <= pick_count(unit1_timebase_sel, timer_count);
      unit1_period <= pick_period(unit1_timebase_sel, timer_period);
      unit2_count  <= pick_count(unit2_timebase_sel, timer_count);
      unit2_period <= pick_period(unit2_timebase_sel, timer_period);
      unit3_count  <= pick_count(unit3_code, timer_count);
      unit3_period <= pick_period(unit3_code, timer_period);
    end
  end

endmodule

// [ccp_timebase_select_chk.sv]
// Routing checker for the capture timebase selector
module ccp_timebase_select_chk #(parameter CNT_W = 16) (
  // Clock and reset
  input wire               aclk,
  input wire               aresetn,
  // Timers
  input wire [6*CNT_W-1:0] timer_count,
  input wire [6*CNT_W-1:0] timer_period,
  // Routed timebases
  input wire [CNT_W-1:0]   unit1_count,
  input wire [CNT_W-1:0]   unit1_period,
  input wire [CNT_W-1:0]   unit2_count,
  input wire [CNT_W-1:0]   unit2_period,
  input wire [CNT_W-1:0]   unit3_count,
  input wire [CNT_W-1:0]   unit3_period,
  // Selections
  input wire [2:0]         unit1_timebase_sel,
  input wire [2:0]         unit2_timebase_sel,
  input wire [1:0]         unit3_timebase_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_u1_zero;
    unit1_timebase_sel == 3'h0 |=>
      unit1_count == $past(timer_count[CNT_W-1:0]) && unit1_period == $past(timer_period[CNT_W-1:0]);
  endproperty
  property p_u1_pair;
    unit1_timebase_sel inside {[3'h1:3'h5]} |=>
      unit1_count == $past(timer_count[2*CNT_W-1:CNT_W]) &&
      unit1_period == $past(timer_period[unit1_timebase_sel*CNT_W +: CNT_W]);
  endproperty
  property p_u2_zero;
    unit2_timebase_sel == 3'h0 |=>
      unit2_count == $past(timer_count[CNT_W-1:0]) && unit2_period == $past(timer_period[CNT_W-1:0]);
  endproperty
  property p_u2_pair;
    unit2_timebase_sel inside {[3'h1:3'h5]} |=>
      unit2_count == $past(timer_count[2*CNT_W-1:CNT_W]) &&
      unit2_period == $past(timer_period[unit2_timebase_sel*CNT_W +: CNT_W]);
  endproperty
  property p_u3_zero;
    unit3_timebase_sel == 2'h0 |=>
      unit3_count == $past(timer_count[CNT_W-1:0]) && unit3_period == $past(timer_period[CNT_W-1:0]);
  endproperty
  property p_u3_pair;
    unit3_timebase_sel inside {[2'h1:2'h3]} |=>
      unit3_count == $past(timer_count[2*CNT_W-1:CNT_W]) &&
      unit3_period == $past(timer_period[unit3_timebase_sel*CNT_W +: CNT_W]);
  endproperty
  property p_rst;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> {unit1_timebase_sel, unit2_timebase_sel, unit3_timebase_sel} == 8'h00;
  endproperty
  a_u1_zero: assert property (p_u1_zero)
    else $error("unit1 route");
  a_u1_pair: assert property (p_u1_pair)
    else $error("unit1 route");
  a_u2_zero: assert property (p_u2_zero)
    else $error("unit2 route");
  a_u2_pair: assert property (p_u2_pair)
    else $error("unit2 route");
  a_u3_zero: assert property (p_u3_zero)
    else $error("unit3 route");
  a_u3_pair: assert property (p_u3_pair)
    else $error("unit3 route");
  a_rst: assert property (p_rst)
    else $error("selection not cleared");
endmodule
bind ccp_timebase_select ccp_timebase_select_chk #(.CNT_W(CNT_W)) u_chk (
  .aclk               (aclk),
  .aresetn            (aresetn),
  .timer_count        (timer_count),
  .timer_period       (timer_period),
  .unit1_count        (unit1_count),
  .unit1_period       (unit1_period),
  .unit2_count        (unit2_count),
  .unit2_period       (unit2_period),
  .unit3_count        (unit3_count),
  .unit3_period       (unit3_period),
  .unit1_timebase_sel (unit1_timebase_sel),
  .unit2_timebase_sel (unit2_timebase_sel),
  .unit3_timebase_sel (unit3_timebase_sel)
);

// [tb_top.sv]
// Register bench for the capture timebase selector
`include "ccp_timebase_select_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] wdata = 0;
  logic [95:0] tc = 96'hf00f_e00e_d00d_c00c_b00b_a00a, tp = 96'h6000_5000_4000_3000_2000_1000;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp, s3;
  wire  [31:0] rdata;
  wire  [15:0] c1, p1, c2, p2, c3, p3;
  wire  [2:0]  s1, s2;
  int          num_errors = 0, comparisons = 0, cyc = 0;
  ccp_timebase_select u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_count(tc), .timer_period(tp), .unit1_count(c1),
    .unit1_period(p1), .unit2_count(c2), .unit2_period(p2), .unit3_count(c3), .unit3_period(p3),
    .unit1_timebase_sel(s1), .unit2_timebase_sel(s2), .unit3_timebase_sel(s3));
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      end_sim;
    end
  end
  task end_sim;
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    @(posedge aclk);
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    check(bresp, er);
    bready <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    check(rdata, ed);
    check(rresp, er);
    rready <= 0;
  endtask
  function logic [31:0] ex(int k);
    return {k ? tc[31:16] : tc[15:0], tp[k*16 +: 16]};
  endfunction
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`TSEL0_OFFSET, 0, `AXI_RESP_OKAY);
    check({c1, p1}, ex(0));
    for (int i = 0; i < 6; i++) begin
      wr(`TSEL0_OFFSET, {2'(i % 3), 3'(5 - i), 3'(i)}, `AXI_RESP_OKAY);
      rd(`TSEL0_OFFSET, {2'(i % 3), 3'(5 - i), 3'(i)}, `AXI_RESP_OKAY);
      check({s3, s2, s1}, {2'(i % 3), 3'(5 - i), 3'(i)});
      check({c1, p1}, ex(i));
      check({c2, p2}, ex(5 - i));
      check({c3, p3}, ex(i % 3));
    end
    wr(4'h4, 32'h0000_00ff, `AXI_RESP_SLVERR);
    rd(4'h4, 0, `AXI_RESP_SLVERR);
    wstrb <= 4'h0;
    wr(`TSEL0_OFFSET, 32'h0000_0000, `AXI_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`TSEL0_OFFSET, 32'h0000_0085, `AXI_RESP_OKAY);
    tc <= ~tc;
    tp <= ~tp;
    repeat (2) @(posedge aclk);
    check({c1, p1}, ex(5));
    check({c2, p2}, ex(0));
    check({c3, p3}, ex(2));
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    check({s3, s2, s1}, 0);
    rd(`TSEL0_OFFSET, 0, `AXI_RESP_OKAY);
    check({c1, p1}, ex(0));
    end_sim;
  end
endmodule
